// [core/btpc_ctl.v]
// Notes on behaviour
// - interrupted write length twice cycle gap
// - burst terminate decode cs low 0011
// - truncated length twice command-to-terminate cycles
// - terminate hits only newest access
// - read data stops read latency later
// - write data stops after the truncated length in beats
// - byte mask per lane each beat
// - precharge decode cs low 1011
// - all-bank flag or bank address select
// - bank ready after single time, or all time on eight-bank parts only
// - array write per four-beat group
// - auto precharge closes bank after burst
// - auto precharge bit on falling ca0
// - read auto precharge start point
// - write auto precharge after recovery
`timescale 1ns/100ps
`include "btpc_regs.vh"
module btpc_ctl #(
    parameter NBANK = 8,
    parameter BAW = 3,
    parameter DW = 64,
    parameter NBYTE = 8,
    parameter CW = `BTPC_CNT_W
) (
    input wire clk_sys,
    input wire rst_n,
    input wire cs_n,
    input wire [9:0] ca_rise,
    input wire [9:0] ca_fall,
    input wire [BAW-1:0] act_bank,
    input wire [CW-1:0] burst_len,
    input wire [CW-1:0] rd_lat,
    input wire [CW-1:0] wr_lat,
    input wire eight_bank,
    input wire [DW-1:0] wr_data,
    input wire [NBYTE-1:0] wr_mask,
    input wire wr_valid,
    output wire wr_ready,
    output wire arr_valid,
    input wire arr_ready,
    output wire [DW+NBYTE-1:0] arr_data,
    output reg rd_data_en_reg,
    output reg [CW-1:0] eff_len_reg,
    output reg [NBANK-1:0] bank_open,
    output reg [NBANK-1:0] bank_ready,
    output reg illegal_cmd_reg
);
    localparam [CW-1:0] RP_PB = (`BTPC_TRPPB_NS + `BTPC_CLK_NS - 1) / `BTPC_CLK_NS;
    localparam [CW-1:0] RP_AB = (`BTPC_TRPAB_NS + `BTPC_CLK_NS - 1) / `BTPC_CLK_NS;
    localparam [CW-1:0] WR_CY = (`BTPC_TWR_NS + `BTPC_CLK_NS - 1) / `BTPC_CLK_NS;
    localparam [CW-1:0] RTP_CY = (`BTPC_TRTP_NS + `BTPC_CLK_NS - 1) / `BTPC_CLK_NS;
    localparam [CW-1:0] ONE = {{(CW-1){1'b0}}, 1'b1};
    localparam [CW-1:0] TWO = {{(CW-2){1'b0}}, 2'b10};

    wire cmd_on = !cs_n;
    wire is_rw = cmd_on && (ca_rise[1:0] == `BTPC_CA_RD_WR);
    wire is_rd = is_rw && ca_rise[`BTPC_CA_RW_BIT];
    wire is_wr = is_rw && !ca_rise[`BTPC_CA_RW_BIT];
    wire is_bst = cmd_on && (ca_rise[3:0] == `BTPC_CA_BST);
    wire is_pre = cmd_on && (ca_rise[3:0] == `BTPC_CA_PRE);
    wire is_act = cmd_on && (ca_rise[1:0] == 2'b10);
    wire ap_bit = ca_fall[`BTPC_CA_AP_BIT];
    wire all_bank = ca_rise[`BTPC_CA_AB_BIT];
    // four-bank parts ignore the top bank bit
    wire [BAW-1:0] pre_bank = eight_bank ? ca_rise[`BTPC_CA_BA_LSB +: BAW] :
        {1'b0, ca_rise[`BTPC_CA_BA_LSB +: BAW-1]};

    // burst tracking for the newest access only
    reg act_reg;
    reg is_wr_reg;
    reg [BAW-1:0] acc_bank_reg;
    reg [CW-1:0] age_reg;
    reg [CW-1:0] len_reg;
    reg [CW-1:0] stop_reg;
    reg stop_pend_reg;
    reg [CW-1:0] wbeat_reg;
    wire [CW-1:0] half_len = len_reg >> 1;
    wire burst_live = act_reg && (age_reg < half_len);
    wire [CW-1:0] cut_len = {age_reg[CW-2:0], 1'b0};
    wire [CW-1:0] lat = is_wr_reg ? wr_lat : rd_lat;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            act_reg <= 1'b0;
            is_wr_reg <= 1'b0;
            acc_bank_reg <= {BAW{1'b0}};
            age_reg <= {CW{1'b0}};
            len_reg <= {CW{1'b0}};
            eff_len_reg <= {CW{1'b0}};
            stop_reg <= {CW{1'b0}};
            stop_pend_reg <= 1'b0;
            rd_data_en_reg <= 1'b0;
            illegal_cmd_reg <= 1'b0;
        end else begin
            if (is_rw) begin
                // a write interrupting a write cuts the first burst
                if (is_wr && burst_live && is_wr_reg) eff_len_reg <= cut_len;
                else if (!burst_live) eff_len_reg <= burst_len;
                act_reg <= 1'b1;
                is_wr_reg <= is_wr;
                acc_bank_reg <= ca_rise[`BTPC_CA_BA_LSB +: BAW];
                age_reg <= ONE;
                len_reg <= burst_len;
                stop_pend_reg <= 1'b0;
                if (burst_live && !is_wr_reg) eff_len_reg <= cut_len;
            end else if (is_bst && burst_live) begin
                eff_len_reg <= cut_len;
                len_reg <= cut_len;
                stop_reg <= lat;
                stop_pend_reg <= 1'b1;
                age_reg <= age_reg + ONE;
            end else if (act_reg) begin
                age_reg <= age_reg + ONE;
                if (stop_pend_reg && stop_reg != {CW{1'b0}}) stop_reg <= stop_reg - ONE;
                if (age_reg >= lat + half_len + TWO) act_reg <= 1'b0;
            end
            rd_data_en_reg <= act_reg && !is_wr_reg && (age_reg >= rd_lat) &&
                (age_reg < rd_lat + half_len) && !(stop_pend_reg && stop_reg == {CW{1'b0}});
            illegal_cmd_reg <= (is_bst && !burst_live) || (is_rw && !bank_open[ca_rise[`BTPC_CA_BA_LSB +: BAW]]);
        end
    end

    // write data path: mask travels with its beat
    reg [CW-1:0] wleft_reg;
    // beats still owed; a cut write drops its unsent tail so the host never hangs
    wire wr_cut = is_wr_reg && burst_live && (is_wr || is_bst);
    wire [CW-1:0] drop_len = wr_cut ? (len_reg - cut_len) : {CW{1'b0}};
    wire [CW-1:0] add_len = is_wr ? burst_len : {CW{1'b0}};
    wire wr_window = (wleft_reg != {CW{1'b0}});
    wire take_beat = wr_valid && wr_window;
    reg [DW-1:0] grp_data_reg;
    reg [NBYTE-1:0] grp_mask_reg;
    reg grp_full_reg;
    wire grp_ready;
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            wbeat_reg <= {CW{1'b0}};
            wleft_reg <= {CW{1'b0}};
            grp_data_reg <= {DW{1'b0}};
            grp_mask_reg <= {NBYTE{1'b0}};
            grp_full_reg <= 1'b0;
        end else begin
            wleft_reg <= wleft_reg - drop_len + add_len - {{(CW-1){1'b0}}, take_beat && wr_ready};
            if (grp_full_reg && grp_ready) grp_full_reg <= 1'b0;
            if (take_beat && wr_ready) begin
                grp_data_reg <= wr_data;
                grp_mask_reg <= wr_mask;
                if (wbeat_reg == `BTPC_PREFETCH - ONE) begin
                    wbeat_reg <= {CW{1'b0}};
                    grp_full_reg <= 1'b1;
                end else begin
                    wbeat_reg <= wbeat_reg + ONE;
                end
            end
        end
    end
    assign wr_ready = !grp_full_reg || grp_ready;

    btpc_skid #(.W(DW + NBYTE)) u_skid (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_valid(grp_full_reg),
        .in_ready(grp_ready),
        .in_data({grp_mask_reg, grp_data_reg}),
        .out_valid(arr_valid),
        .out_ready(arr_ready),
        .out_data(arr_data)
    );

    // auto precharge delays
    wire [CW-1:0] rd_ap_a = burst_len >> 1;
    wire [CW-1:0] rd_ap_b = (burst_len >> 1) - TWO + RTP_CY;
    wire [CW-1:0] rd_ap = (rd_ap_a > rd_ap_b) ? rd_ap_a : rd_ap_b;
    wire [CW-1:0] wr_ap = wr_lat + (burst_len >> 1) + ONE + WR_CY;

    wire [NBANK-1:0] rdy_w;
    wire [NBANK-1:0] open_w;
    genvar g;
    generate
        for (g = 0; g < NBANK; g = g + 1) begin : g_bank
            wire hit_pre = is_pre && (all_bank || pre_bank == g);
            btpc_bank #(.CW(CW)) u_bank (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .act(is_act && act_bank == g),
                .pre(hit_pre),
                .pre_cycles((all_bank && eight_bank) ? RP_AB : RP_PB),
                .ap_arm(is_rw && ap_bit && ca_rise[`BTPC_CA_BA_LSB +: BAW] == g),
                .ap_delay(is_wr ? wr_ap : rd_ap),
                .ap_rp(RP_PB),
                .open_reg(open_w[g]),
                .ready(rdy_w[g]),
                .ap_fire()
            );
        end
    endgenerate
    always @* begin
        bank_open = open_w;
        bank_ready = rdy_w;
    end
endmodule // btpc_ctl

// [core/btpc_regs.vh]
`ifndef BTPC_REGS_VH
`define BTPC_REGS_VH
// command decode bits on the rising-edge ca word; the auto precharge bit is on the falling-edge word
`define BTPC_CA_RD_WR 2'b01
`define BTPC_CA_BST 4'b0011
`define BTPC_CA_PRE 4'b1011
`define BTPC_CA_ACT_BIT 0
`define BTPC_CA_RW_BIT 2
`define BTPC_CA_AB_BIT 4
`define BTPC_CA_BA_LSB 7
`define BTPC_CA_AP_BIT 0
// timing in ns at 40 MHz
`define BTPC_CLK_NS 25
`define BTPC_TRPPB_NS 18
`define BTPC_TRPAB_NS 21
`define BTPC_TWR_NS 15
`define BTPC_TRTP_NS 8
`define BTPC_PREFETCH 5'h04
`define BTPC_CNT_W 5
`endif

// [core/btpc_skid.v]
`timescale 1ns/100ps
module btpc_skid #(
    parameter W = 8
) (
    input wire clk_sys,
    input wire rst_n,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] d0_reg;
    reg [W-1:0] d1_reg;
    reg [1:0] cnt_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (cnt_reg != 2'h2);
    assign out_valid = (cnt_reg != 2'h0);
    assign out_data = d0_reg;
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_reg <= 2'h0;
            d0_reg <= {W{1'b0}};
            d1_reg <= {W{1'b0}};
        end else begin
            case ({push, pop})
                2'b10: begin
                    if (cnt_reg == 2'h0) d0_reg <= in_data;
                    else d1_reg <= in_data;
                    cnt_reg <= cnt_reg + 2'h1;
                end
                2'b01: begin
                    d0_reg <= d1_reg;
                    cnt_reg <= cnt_reg - 2'h1;
                end
                2'b11: begin
                    if (cnt_reg == 2'h1) d0_reg <= in_data;
                    else begin
                        d0_reg <= d1_reg;
                        d1_reg <= in_data;
                    end
                end
                default: begin
                end
            endcase
        end
    end
endmodule // btpc_skid

// [core/btpc_bank.v]
`timescale 1ns/100ps
`include "btpc_regs.vh"
// one bank: open flag, precharge countdown, auto precharge countdown
module btpc_bank #(
    parameter CW = 5
) (
    input wire clk_sys,
    input wire rst_n,
    input wire act,
    input wire pre,
    input wire [CW-1:0] pre_cycles,
    input wire ap_arm,
    input wire [CW-1:0] ap_delay,
    input wire [CW-1:0] ap_rp,
    output reg open_reg,
    output wire ready,
    output wire ap_fire
);
    reg [CW-1:0] rp_reg;
    reg [CW-1:0] ap_reg;
    reg ap_pend_reg;
    assign ap_fire = ap_pend_reg && (ap_reg == {CW{1'b0}});
    assign ready = !open_reg && (rp_reg == {CW{1'b0}});
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            open_reg <= 1'b0;
            rp_reg <= {CW{1'b0}};
            ap_reg <= {CW{1'b0}};
            ap_pend_reg <= 1'b0;
        end else begin
            if (act) begin
                open_reg <= 1'b1;
            end else if (pre || ap_fire) begin
                open_reg <= 1'b0;
            end
            if (pre) rp_reg <= pre_cycles;
            else if (ap_fire) rp_reg <= ap_rp;
            else if (rp_reg != {CW{1'b0}}) rp_reg <= rp_reg - {{(CW-1){1'b0}}, 1'b1};
            if (ap_arm) begin
                ap_pend_reg <= 1'b1;
                ap_reg <= ap_delay;
            end else if (ap_fire) begin
                ap_pend_reg <= 1'b0;
            end else if (ap_pend_reg) begin
                ap_reg <= ap_reg - {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // btpc_bank

// [bench/btpc_chk_assertions.sv]
`timescale 1ns/100ps
`include "btpc_regs.vh"
module btpc_chk (
    input wire clk_sys,
    input wire rst_n,
    input wire cs_n,
    input wire [9:0] ca_rise,
    input wire [2:0] act_bank,
    input wire [4:0] burst_len,
    input wire eight_bank,
    input wire arr_valid,
    input wire arr_ready,
    input wire [71:0] arr_data,
    input wire [4:0] eff_len_reg,
    input wire [7:0] bank_open,
    input wire illegal_cmd_reg
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    reg [4:0] age_reg;
    wire acc = !cs_n && ca_rise[1:0] == `BTPC_CA_RD_WR;
    wire pre = !cs_n && ca_rise[3:0] == `BTPC_CA_PRE;
    wire bst = !cs_n && ca_rise[3:0] == `BTPC_CA_BST;
    // saturates so a long-gone access never looks live
    always @(posedge clk_sys) begin
        if (!rst_n)
            age_reg <= 5'h1f;
        else if (acc)
            age_reg <= 5'h01;
        else if (age_reg != 5'h1f)
            age_reg <= age_reg + 5'h01;
    end
    sequence s_bst_live;
        bst && !age_reg[0] && age_reg != 5'h00 && age_reg < burst_len[4:1];
    endsequence
    sequence s_stuck;
        arr_valid && !arr_ready;
    endsequence
    property p_bst_len;
        s_bst_live |=> eff_len_reg == {$past(age_reg[3:0]), 1'b0};
    endproperty
    a_bst_len: assert property (p_bst_len) else $error("truncated length wrong");
    property p_bst_idle;
        bst && age_reg == 5'h1f |=> illegal_cmd_reg;
    endproperty
    a_bst_idle: assert property (p_bst_idle) else $error("stray terminate not flagged");
    property p_acc_len;
        acc && age_reg >= {1'b0, burst_len[4:1]} |=> eff_len_reg == $past(burst_len);
    endproperty
    a_acc_len: assert property (p_acc_len) else $error("access length wrong");
    property p_act;
        !cs_n && ca_rise[1:0] == 2'b10 |=> bank_open[$past(act_bank)];
    endproperty
    a_act: assert property (p_act) else $error("bank not opened");
    property p_pre_all;
        pre && ca_rise[`BTPC_CA_AB_BIT] |=> bank_open == 8'h00;
    endproperty
    a_pre_all: assert property (p_pre_all) else $error("all-bank close failed");
    property p_pre8;
        pre && !ca_rise[4] && eight_bank |=> !bank_open[$past(ca_rise[9:7])];
    endproperty
    a_pre8: assert property (p_pre8) else $error("bank close failed");
    property p_pre4;
        pre && !ca_rise[4] && !eight_bank |=> !bank_open[$past(ca_rise[8:7])];
    endproperty
    a_pre4: assert property (p_pre4) else $error("four-bank close failed");
    property p_arr_hold;
        s_stuck |=> arr_valid && $stable(arr_data);
    endproperty
    a_arr_hold: assert property (p_arr_hold) else $error("array word lost");
endmodule // btpc_chk
bind btpc_ctl btpc_chk chk (.clk_sys, .rst_n, .cs_n, .ca_rise, .act_bank, .burst_len, .eight_bank,
    .arr_valid, .arr_ready, .arr_data, .eff_len_reg, .bank_open, .illegal_cmd_reg);

// [bench/btpc_host.sv]
`timescale 1ns/100ps
module btpc_host (
    input wire clk_sys,
    input wire rst_n,
    input wire load,
    input wire [4:0] count,
    input wire stall,
    input wire wr_ready,
    output wire wr_valid,
    output wire [63:0] wr_data,
    output wire [7:0] wr_mask,
    output wire arr_ready
);
    reg [4:0] left_reg;
    reg [7:0] seq_reg;
    wire take = wr_valid && wr_ready;
    assign wr_valid = left_reg != 5'h00;
    // idle lines show the inverse so stale beats cannot match
    assign wr_data = {4{seq_reg, ~seq_reg}} ^ {64{!wr_valid}};
    assign wr_mask = seq_reg ^ 8'h5a ^ {8{!wr_valid}};
    assign arr_ready = !stall;
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            left_reg <= 5'h00;
            seq_reg <= 8'h00;
        end else begin
            left_reg <= left_reg + (load ? count : 5'h00) - {4'h0, take};
            seq_reg <= seq_reg + {7'h00, take};
        end
    end
endmodule // btpc_host

// [bench/test_burst_truncate_precharge_ctl.sv]
`timescale 1ns/100ps
module test_burst_truncate_precharge_ctl;
    reg clk_sys = 1'b0, rst_n = 1'b0, cs_n = 1'b1, eight_bank = 1'b1, load = 1'b0, stall = 1'b0, hold = 1'b0;
    reg [9:0] ca_rise = 10'h000, ca_fall = 10'h000;
    reg [2:0] act_bank = 3'h0;
    reg [4:0] burst_len = 5'h08, count = 5'h00;
    reg [7:0] ex;
    reg [2:0] bk;
    reg [1:0] beat = 2'h0;
    reg [31:0] st = 32'h0000_80ce;
    reg [71:0] q[$];
    integer miscompares = 0, num_checks = 0, i, j, n;
    wire wr_valid, wr_ready, arr_valid, arr_ready, rd_data_en_reg, illegal_cmd_reg;
    wire [63:0] wr_data;
    wire [7:0] wr_mask, bank_open;
    wire [71:0] arr_data;
    wire [4:0] eff_len_reg;
    always #12.5 clk_sys = ~clk_sys;
    btpc_ctl uut (.clk_sys, .rst_n, .cs_n, .ca_rise, .ca_fall, .act_bank, .burst_len, .rd_lat(5'h03),
        .wr_lat(5'h01), .eight_bank, .wr_data, .wr_mask, .wr_valid, .wr_ready, .arr_valid, .arr_ready,
        .arr_data, .rd_data_en_reg, .eff_len_reg, .bank_open, .bank_ready(), .illegal_cmd_reg);
    btpc_host host (.clk_sys, .rst_n, .load, .count, .stall, .wr_ready, .wr_valid, .wr_data, .wr_mask,
        .arr_ready);
    function [31:0] xs(input [31:0] v);
        reg [31:0] t;
        begin
            t = v ^ (v << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    task conclude;
        begin
            if (miscompares == 0 && num_checks > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    task cmp(input [71:0] got, input [71:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("ERROR %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task cmd(input [9:0] r, input [9:0] f, input [4:0] nb);
        begin
            @(posedge clk_sys);
            cs_n <= 1'b0;
            ca_rise <= r;
            ca_fall <= f;
            load <= nb != 5'h00;
            count <= nb;
            @(posedge clk_sys);
            cs_n <= 1'b1;
            load <= 1'b0;
            #1;
        end
    endtask
    task tick(input integer lim);
        begin
            @(posedge clk_sys);
            n = n + 1;
            if (n > lim) begin
                miscompares = miscompares + 1;
                conclude;
            end
        end
    endtask
    task drain;
        begin
            n = 0;
            while (q.size() != 0 || wr_valid)
                tick(300);
            repeat (4) @(posedge clk_sys);
        end
    endtask
    task openall;
        for (i = 0; i < 8; i = i + 1) begin
            act_bank <= i[2:0];
            cmd(10'h002, 10'h000, 5'h00);
        end
    endtask
    // random stalls on the array side; hold forces a long stall
    always @(posedge clk_sys) begin
        st <= xs(st);
        stall <= hold | st[0];
        if (wr_valid && wr_ready) begin
            beat <= beat + 2'h1;
            if (beat == 2'h3)
                q.push_back({wr_mask, wr_data});
        end
        if (arr_valid && arr_ready)
            cmp(arr_data, q.size() ? q.pop_front() : ~arr_data);
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        openall;
        cmp(bank_open, 8'hff);
        ex = 8'hff;
        for (j = 0; j < 4; j = j + 1) begin
            bk = st[2:0];
            cmd({bk, 3'h0, 4'hb}, 10'h000, 5'h00);
            ex[bk] = 1'b0;
            cmp(bank_open, ex);
        end
        openall;
        eight_bank <= 1'b0;
        bk = st[2:0];
        cmd({1'b1, bk[1:0], 7'h0b}, 10'h000, 5'h00);
        ex = 8'hff;
        ex[bk[1:0]] = 1'b0;
        cmp(bank_open, ex);
        eight_bank <= 1'b1;
        cmd(10'h01b, 10'h000, 5'h00);
        cmp(bank_open, 8'h00);
        openall;
        cmd(10'h001, 10'h000, 5'h08);
        cmp(eff_len_reg, 5'h08);
        drain;
        cmd(10'h001, 10'h000, 5'h04);
        cmd(10'h001, 10'h000, 5'h08);
        cmp(eff_len_reg, 5'h04);
        drain;
        burst_len <= 5'h10;
        for (j = 0; j < 6; j = j + 1) begin
            cmd(j[0] ? 10'h005 : 10'h001, 10'h000, j[0] ? 5'h00 : 5'h04 * (j / 2 + 1));
            repeat (2 * (j / 2)) @(posedge clk_sys);
            cmd(10'h003, 10'h000, 5'h00);
            cmp(eff_len_reg, 5'h04 * (j / 2 + 1));
            drain;
        end
        hold <= 1'b1;
        cmd(10'h001, 10'h000, 5'h10);
        repeat (40) @(posedge clk_sys);
        cmp(wr_valid, 1'b1);
        hold <= 1'b0;
        drain;
        cmd(10'h003, 10'h000, 5'h00);
        cmp(illegal_cmd_reg, 1'b1);
        cmp(bank_open[1:0], 2'h3);
        for (j = 0; j < 2; j = j + 1) begin
            cmd({j[2:0], 4'h0, j[0], 2'h1}, 10'h001, j[0] ? 5'h00 : 5'h10);
            n = 0;
            while (bank_open[j])
                tick(60);
            cmp(bank_open[j], 1'b0);
            drain;
        end
        conclude;
    end
endmodule // test_burst_truncate_precharge_ctl
